//--- common/multiprotocol_serial_transmitter_defs.vh
// constants for the multiprotocol serial transmitter
`ifndef MULTIPROTOCOL_SERIAL_TRANSMITTER_DEFS_VH
`define MULTIPROTOCOL_SERIAL_TRANSMITTER_DEFS_VH

// operating modes (op_mode)
`define MODE_ASYNC      3'h0
`define MODE_MONOSYNC   3'h1
`define MODE_BISYNC     3'h2
`define MODE_EXTSYNC    3'h3
`define MODE_SDLC       3'h4

// clock mode field and transmit clock edges per bit
`define CLK_X1          2'h0
`define CLK_X16         2'h1
`define CLK_X32         2'h2
`define CLK_X64         2'h3
`define DIV_X1          8'h01
`define DIV_X16         8'h10
`define DIV_X32         8'h20
`define DIV_X64         8'h40

// stop bit field (0 is taken as one stop bit)
`define STOP_1          2'h1
`define STOP_1P5        2'h2
`define STOP_2          2'h3

// crc polynomials and presets
`define POLY_CRC16      16'h8005
`define POLY_CCITT      16'h1021
`define CRC_PRESET_SDLC 16'hFFFF
`define CRC_PRESET_COP  16'h0000
`define CRC_LEN         5'h10

// bit-oriented framing
`define SDLC_FLAG       8'h7E
`define STUFF_RUN       3'h5
`define ABORT_ONES      5'h0C

`endif

//--- hw/multiprotocol_serial_transmitter.v
// transmitter section of one serial controller channel
`timescale 1ns/100ps
`include "multiprotocol_serial_transmitter_defs.vh"

// Summary of operation
// - double-buffer characters; buffer moves to shifter when it is free; LSB first
// - becoming-empty flag set per transfer; cleared by write or reset-pending command
// - buffer-empty status always shows whether the buffer holds a character
// - line marks after reset; send-break forces it low and discards the character
// - clock mode selects 1x, 16x, 32x or 64x transmit clock per bit
// - each new bit goes out on a falling transmit clock edge
// - async: line marks after enable until first character is written
// - async frame: start, data, optional parity, 1, 1.5 or 2 stop bits
// - async: no data keeps the line high and all-sent set
// - async disable finishes the character; flag and request stay
// - request-to-send active at once; async release waits for empty transmitter
// - auto-enables gate character start on clear-to-send; else change only flagged
// - bisync sends low then high sync byte; monosync and external sync the low byte
// - sync modes mark while disabled, then send sync until data is loaded
// - idle/crc latch set at init; entering idle from data sets becoming-empty
// - latch cleared: next underrun sends crc, sets latch and status change
// - disable finishes the character; in crc phase sync bits replace crc bits
// - selectable crc polynomial; reset-crc command clears it outside sdlc
// - crc enable sampled per character when it is written
// - sdlc inserts a zero after five ones in data and crc
// - abort sends twelve ones, discards shifter and buffer, then idles
// - sdlc crc presets to ones and goes out inverted
// - parity bit makes the count of ones even or odd as selected
// - sdlc flag 01111110 is the idle character and is never stuffed

module multiprotocol_serial_transmitter (
	// clock and reset
	input  wire       core_clk,
	input  wire       reset,
	// host data and commands
	input  wire [7:0] data_in,
	input  wire       data_write,
	input  wire       cmd_reset_tx,
	input  wire       cmd_reset_tx_pending,
	input  wire       cmd_reset_idle_crc,
	input  wire       cmd_reset_crc,
	input  wire       cmd_send_abort,
	// configuration
	input  wire [2:0] op_mode,
	input  wire [1:0] clock_mode,
	input  wire [1:0] bits_per_char,
	input  wire [1:0] stop_bits,
	input  wire       parity_enable,
	input  wire       parity_even,
	input  wire       tx_enable,
	input  wire       send_break,
	input  wire       rts_control,
	input  wire       auto_enables,
	input  wire       crc_enable,
	input  wire       crc_poly_ccitt,
	input  wire [7:0] sync_char_low,
	input  wire [7:0] sync_char_high,
	// serial line
	input  wire       transmit_clock_in,
	input  wire       cts_n,
	output reg        txd,
	output reg        rts_n,
	// status
	output wire       tx_buffer_empty,
	output reg        tx_becoming_empty,
	output wire       tx_request,
	output reg        all_sent,
	output reg        idle_crc_latch,
	output reg        ext_status_change,
	output wire       cts_status
);

localparam S_OFF   = 6'b000001;
localparam S_ASYNC = 6'b000010;
localparam S_SYNC  = 6'b000100;
localparam S_DATA  = 6'b001000;
localparam S_CRC   = 6'b010000;
localparam S_ABORT = 6'b100000;

function [15:0] crc_step;
	input [15:0] c;
	input        b;
	input        ccitt;
	begin
		crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? (ccitt ? `POLY_CCITT : `POLY_CRC16)
			: 16'h0000);
	end
endfunction

function [15:0] rev16;
	input [15:0] v;
	integer i;
	begin
		for (i = 0; i < 16; i = i + 1) begin
			rev16[i] = v[15 - i];
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg  [2:0]  txc_sync;
reg  [2:0]  cts_sync;
reg         txc_level;
reg         cts_level;
reg  [5:0]  state;
reg  [15:0] shifter;
reg  [4:0]  bits_left;
reg  [7:0]  cnt;
reg  [7:0]  bit_len;
reg  [2:0]  ones;
reg  [15:0] crc;
reg  [7:0]  buf_data;
reg         buf_full;
reg         buf_crc;
reg         char_crc;
reg         abort_req;
reg         rts_hold;

////////////////////////////////////////////////////////////////////////////////
// decoding

wire rst      = reset | cmd_reset_tx;
wire is_async = (op_mode == `MODE_ASYNC);
wire is_sdlc  = (op_mode == `MODE_SDLC);
wire is_bisync = (op_mode == `MODE_BISYNC);
// edges count only once the second and third stages agree
wire txc_fall = (txc_sync[1] == txc_sync[2]) && !txc_sync[2] && txc_level;
wire cts_change = (cts_sync[1] == cts_sync[2]) && (cts_sync[2] != cts_level);
wire go = tx_enable && (!auto_enables || !cts_level);

reg  [7:0] div_len;
always @* begin
	case (clock_mode)
	`CLK_X16: div_len = `DIV_X16;
	`CLK_X32: div_len = `DIV_X32;
	`CLK_X64: div_len = `DIV_X64;
	default:  div_len = `DIV_X1;
	endcase
end

// 1.5 stop bits in 1x mode collapses to one bit time
wire [7:0] stop_len = (stop_bits == `STOP_2) ? {div_len[6:0], 1'b0} :
	(stop_bits == `STOP_1P5) ? div_len + {1'b0, div_len[7:1]} : div_len;
wire [7:0] cnt_inc   = cnt + 8'h01;
wire       edge_done = (cnt_inc >= bit_len);
wire       stuff_now = txc_fall && edge_done && is_sdlc && ((state == S_DATA) ||
	(state == S_CRC)) && (ones == `STUFF_RUN);

wire [3:0]  nbits   = 4'h5 + {2'h0, bits_per_char};
wire [7:0]  data_m  = buf_data & (8'hFF >> (2'h3 - bits_per_char));
wire        par_bit = parity_even ? ^data_m : ~^data_m;
wire [4:0]  par_pos = {1'b0, nbits} + 5'h01;
wire [15:0] async_frame = (16'hFFFF << (par_pos + {4'h0, parity_enable})) |
	({15'h0000, par_bit} << par_pos) | {7'h00, data_m, 1'b0};
wire [4:0]  async_len = par_pos + 5'h01 + {4'h0, parity_enable};
wire [15:0] sync_word = is_sdlc ? {`SDLC_FLAG, `SDLC_FLAG} :
	is_bisync ? {sync_char_high, sync_char_low} : {sync_char_low, sync_char_low};
wire [4:0]  crc_pos = 5'h10 - bits_left;

////////////////////////////////////////////////////////////////////////////////
// bit sequencer

reg        next_txd;
reg [15:0] next_shifter;
reg [4:0]  next_bits_left;
reg [5:0]  next_state;
reg [7:0]  next_cnt;
reg [2:0]  next_ones;
reg [15:0] pat;
reg [4:0]  plen;
reg        ld;
reg        placed;
reg        take;
reg        set_be;
reg        crc_enter;
reg        abort_go;
reg        crc_bit_en;
reg        crc_bit;

always @* begin
	next_txd       = txd;
	next_shifter   = shifter;
	next_bits_left = bits_left;
	next_state     = state;
	next_cnt       = cnt;
	next_ones      = ones;
	pat            = 16'hFFFF;
	plen           = 5'h01;
	ld             = 1'b0;
	placed         = 1'b0;
	take           = 1'b0;
	set_be         = 1'b0;
	crc_enter      = 1'b0;
	abort_go       = 1'b0;
	crc_bit_en     = 1'b0;
	crc_bit        = 1'b0;
	if (send_break) begin
		next_txd       = 1'b0;
		next_state     = S_OFF;
		next_bits_left = 5'h00;
		next_cnt       = 8'h00;
	end else if (txc_fall) begin
		next_cnt = cnt_inc;
		if (abort_req) begin
			abort_go   = 1'b1;
			ld         = 1'b1;
			plen       = `ABORT_ONES;
			next_state = S_ABORT;
		end else if (stuff_now) begin
			next_txd = 1'b0;
			next_cnt = 8'h00;
			placed   = 1'b1;
		end else if (edge_done && bits_left != 5'h00) begin
			// a crc cut short by disable is padded with sync bits in step
			next_txd = (state == S_CRC && !tx_enable) ? sync_word[crc_pos[3:0]] :
				shifter[0];
			next_shifter   = {1'b1, shifter[15:1]};
			next_bits_left = bits_left - 5'h01;
			next_cnt       = 8'h00;
			placed         = 1'b1;
			crc_bit_en     = (state == S_DATA) && char_crc;
			crc_bit        = shifter[0];
		end else if (state == S_OFF || edge_done) begin
			next_cnt = 8'h00;
			if (is_async) begin
				if (go && buf_full) begin
					ld         = 1'b1;
					take       = 1'b1;
					set_be     = 1'b1;
					pat        = async_frame;
					plen       = async_len;
					next_state = S_ASYNC;
				end else begin
					next_txd   = 1'b1;
					next_state = S_OFF;
				end
			end else if (!go) begin
				next_txd   = 1'b1;
				next_state = S_OFF;
			end else if (buf_full) begin
				ld         = 1'b1;
				take       = 1'b1;
				set_be     = 1'b1;
				pat        = {8'hFF, data_m};
				plen       = {1'b0, nbits};
				next_state = S_DATA;
				crc_bit_en = buf_crc;
				crc_bit    = data_m[0];
			end else if (state == S_DATA && !idle_crc_latch) begin
				ld         = 1'b1;
				crc_enter  = 1'b1;
				pat        = rev16(is_sdlc ? ~crc : crc);
				plen       = `CRC_LEN;
				next_state = S_CRC;
			end else begin
				ld         = 1'b1;
				set_be     = (state == S_DATA);
				pat        = is_sdlc ? {8'hFF, `SDLC_FLAG} : sync_word;
				plen       = (is_bisync && !is_sdlc) ? 5'h10 : 5'h08;
				next_state = S_SYNC;
			end
		end
	end else if (state == S_OFF) begin
		// a break that has just been lifted must not leave the line spacing
		next_txd = 1'b1;
	end
	if (ld) begin
		next_txd       = pat[0];
		next_shifter   = {1'b1, pat[15:1]};
		next_bits_left = plen - 5'h01;
		next_cnt       = 8'h00;
		placed         = 1'b1;
	end
	// flags and aborts reset the run so they never trigger insertion
	if (placed) begin
		next_ones = (is_sdlc && (next_state == S_DATA || next_state == S_CRC) && next_txd) ?
			ones + 3'h1 : 3'h0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// state update

always @(posedge core_clk) begin
	txc_sync <= {txc_sync[1:0], transmit_clock_in};
	cts_sync <= {cts_sync[1:0], cts_n};
	if (rst) begin
		txc_level         <= 1'b1;
		cts_level         <= 1'b1;
		state             <= S_OFF;
		txd               <= 1'b1;
		shifter           <= 16'hFFFF;
		bits_left         <= 5'h00;
		cnt               <= 8'h00;
		bit_len           <= `DIV_X1;
		ones              <= 3'h0;
		crc               <= `CRC_PRESET_COP;
		buf_data          <= 8'h00;
		buf_full          <= 1'b0;
		buf_crc           <= 1'b0;
		char_crc          <= 1'b0;
		abort_req         <= 1'b0;
		rts_hold          <= 1'b0;
		rts_n             <= 1'b1;
		tx_becoming_empty <= 1'b0;
		all_sent          <= 1'b1;
		idle_crc_latch    <= 1'b1;
		ext_status_change <= 1'b0;
	end else begin
		if (txc_sync[1] == txc_sync[2]) begin
			txc_level <= txc_sync[2];
		end
		if (cts_sync[1] == cts_sync[2]) begin
			cts_level <= cts_sync[2];
		end
		ext_status_change <= cts_change | crc_enter;
		state     <= next_state;
		txd       <= next_txd;
		shifter   <= next_shifter;
		bits_left <= next_bits_left;
		cnt       <= next_cnt;
		ones      <= next_ones;
		// the last async bit is the stop bit and may be stretched
		bit_len   <= (next_state == S_ASYNC && next_bits_left == 5'h00) ? stop_len : div_len;
		if (data_write) begin
			buf_data <= data_in;
			buf_crc  <= crc_enable;
			buf_full <= 1'b1;
		end else if (take || cmd_send_abort) begin
			buf_full <= 1'b0;
		end
		if (take) begin
			char_crc <= buf_crc;
		end
		// a transfer in the same cycle as a clear keeps the flag set
		if (set_be) begin
			tx_becoming_empty <= 1'b1;
		end else if (data_write || cmd_reset_tx_pending) begin
			tx_becoming_empty <= 1'b0;
		end
		if (crc_enter) begin
			idle_crc_latch <= 1'b1;
		end else if (cmd_reset_idle_crc) begin
			idle_crc_latch <= 1'b0;
		end
		if (cmd_send_abort) begin
			abort_req <= 1'b1;
		end else if (abort_go) begin
			abort_req <= 1'b0;
		end
		if (cmd_reset_crc) begin
			crc <= is_sdlc ? `CRC_PRESET_SDLC : `CRC_PRESET_COP;
		end else if (crc_bit_en) begin
			crc <= crc_step(crc, crc_bit, crc_poly_ccitt);
		end
		if (rts_control) begin
			rts_hold <= 1'b1;
		end else if (!buf_full && state == S_OFF) begin
			rts_hold <= 1'b0;
		end
		rts_n    <= ~(rts_control | (is_async & rts_hold));
		all_sent <= is_async && state == S_OFF && !buf_full;
	end
end

assign tx_buffer_empty = ~buf_full;
assign tx_request      = tx_becoming_empty;
assign cts_status      = ~cts_level;

endmodule

//--- testbench/multiprotocol_serial_transmitter_props.sv
// port assertions for the multiprotocol serial transmitter
`timescale 1ns/100ps
`include "multiprotocol_serial_transmitter_defs.vh"
module tx_props (
	// clock and reset
	input logic       core_clk,
	input logic       reset,
	// host side
	input logic       data_write,
	input logic       cmd_reset_tx,
	input logic       cmd_reset_tx_pending,
	input logic       cmd_reset_idle_crc,
	input logic       cmd_send_abort,
	input logic [2:0] op_mode,
	input logic       send_break,
	input logic       rts_control,
	// line and status
	input logic       cts_n,
	input logic       txd,
	input logic       rts_n,
	input logic       tx_buffer_empty,
	input logic       tx_becoming_empty,
	input logic       tx_request,
	input logic       all_sent,
	input logic       idle_crc_latch,
	input logic       ext_status_change,
	input logic       cts_status
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	// a buffer emptied by anything but a reset or an abort is a transfer into the shifter
	sequence s_xfer;
		$rose(tx_buffer_empty) && !$past(cmd_reset_tx) && !$past(cmd_send_abort);
	endsequence
	property p_xfer; s_xfer |-> tx_becoming_empty; endproperty
	property p_brk; send_break && !cmd_reset_tx |=> !txd; endproperty
	property p_rts_on; rts_control && !cmd_reset_tx |=> !rts_n; endproperty
	property p_rts_hold;
		op_mode == `MODE_ASYNC && !rts_n && !tx_buffer_empty && !cmd_reset_tx |=> !rts_n;
	endproperty
	property p_fill; data_write && !cmd_reset_tx |=> !tx_buffer_empty; endproperty
	property p_wclr;
		data_write && tx_buffer_empty && op_mode == `MODE_ASYNC && !cmd_reset_tx
			|=> !tx_becoming_empty;
	endproperty
	property p_pclr;
		cmd_reset_tx_pending && tx_buffer_empty && !data_write && op_mode == `MODE_ASYNC
			|=> !tx_becoming_empty;
	endproperty
	property p_req; tx_request == tx_becoming_empty; endproperty
	// a transmitter reset parks the filtered level high for one cycle
	property p_cts; !cts_n [*6] ##0 !$past(cmd_reset_tx) |-> cts_status; endproperty
	property p_esc; $changed(cts_status) && !$past(cmd_reset_tx) |-> ext_status_change;
	endproperty
	property p_idle;
		op_mode == `MODE_ASYNC && all_sent && !send_break && !$past(send_break) |-> txd;
	endproperty
	property p_latch;
		idle_crc_latch && !cmd_reset_idle_crc && !cmd_reset_tx |=> idle_crc_latch;
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer without becoming empty");
	a_brk: assert property (p_brk) else $error("break not driving line low");
	a_rts_on: assert property (p_rts_on) else $error("rts not active");
	a_rts_hold: assert property (p_rts_hold) else $error("rts released early");
	a_fill: assert property (p_fill) else $error("write left buffer empty");
	a_wclr: assert property (p_wclr) else $error("write kept flag set");
	a_pclr: assert property (p_pclr) else $error("pending reset kept flag");
	a_req: assert property (p_req) else $error("request differs from flag");
	a_cts: assert property (p_cts) else $error("cts status wrong");
	a_esc: assert property (p_esc) else $error("cts change not flagged");
	a_idle: assert property (p_idle) else $error("idle line not high");
	a_latch: assert property (p_latch) else $error("latch dropped");
endmodule

bind multiprotocol_serial_transmitter tx_props u_props (.core_clk, .reset, .data_write,
	.cmd_reset_tx, .cmd_reset_tx_pending, .cmd_reset_idle_crc, .cmd_send_abort, .op_mode,
	.send_break, .rts_control, .cts_n, .txd, .rts_n, .tx_buffer_empty, .tx_becoming_empty,
	.tx_request, .all_sent, .idle_crc_latch, .ext_status_change, .cts_status);

//--- testbench/serial_peer.sv
// modem side: makes the transmit clock and clear-to-send, samples the data line
`timescale 1ns/100ps
module serial_peer (
	input  logic        run,
	input  logic        cts_on,
	input  logic        txd,
	output logic        transmit_clock_in,
	output logic        cts_n,
	output logic [31:0] line_bits,
	output int          bit_cnt
);
	// parked high between frames so no stray fall reaches the shifter
	initial begin
		transmit_clock_in = 1'b1;
		forever begin
			#62.5;
			transmit_clock_in = run ? ~transmit_clock_in : 1'b1;
		end
	end
	assign cts_n = ~cts_on;
	initial begin
		line_bits = 32'h0000_0000;
		bit_cnt = 0;
	end
	// sample mid-bit, the device moves the line on the fall
	always @(posedge transmit_clock_in) begin
		line_bits <= {txd, line_bits[31:1]};
		bit_cnt <= bit_cnt + 1;
	end
endmodule

//--- testbench/multiprotocol_serial_transmitter_test.sv
// self-checking bench for the multiprotocol serial transmitter
`timescale 1ns/100ps
`include "multiprotocol_serial_transmitter_defs.vh"
module multiprotocol_serial_transmitter_test;
	logic core_clk, reset, data_write, cmd_reset_tx, cmd_reset_tx_pending, cmd_reset_idle_crc;
	logic cmd_reset_crc, cmd_send_abort, tx_enable, send_break, rts_control, auto_enables;
	logic crc_enable, crc_poly_ccitt, parity_enable, parity_even, run, cts_on;
	logic [7:0] data_in, sync_char_low, sync_char_high;
	logic [2:0] op_mode;
	logic [1:0] clock_mode, bits_per_char, stop_bits;
	logic txd, rts_n, tx_buffer_empty, tx_becoming_empty, tx_request, all_sent;
	logic idle_crc_latch, ext_status_change, cts_status, transmit_clock_in, cts_n;
	logic [31:0] line_bits;
	int bit_cnt, miscompares, cmp_count;

	multiprotocol_serial_transmitter u_dut (.*);
	serial_peer u_peer (.*);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task wr(input logic [7:0] d);
		data_in <= d;
		data_write <= 1'b1;
		tick(1);
		data_write <= 1'b0;
		tick(1);
	endtask
	// run the link clock for n bit samples, then park it
	task cap(input int n);
		int c0;
		c0 = bit_cnt;
		run <= 1'b1;
		for (int i = 0; i < n * 30 + 10 && bit_cnt < c0 + n; i++) tick(1);
		run <= 1'b0;
		tick(1);
		chk(bit_cnt - c0, n, "bit count");
	endtask
	task give_verdict;
		$display("comparisons %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_async;
		tx_enable <= 1'b1;
		cap(3);
		chk(line_bits[31:29], 3'h7, "marking before data");
		wr(8'h07);
		chk(tx_buffer_empty, 1'b0, "buffer empty after write");
		cap(1);
		wr(8'h81);
		cap(21);
		chk(line_bits[31:10], {1'b1, 1'b0, 8'h81, 1'b0, 1'b1, 1'b1, 8'h07, 1'b0}, "frames");
		cap(2);
		chk({line_bits[31:30], all_sent}, 3'h7, "all sent");
		chk({tx_becoming_empty, tx_request}, 2'h3, "becoming empty");
		cmd_reset_tx_pending <= 1'b1;
		tick(1);
		cmd_reset_tx_pending <= 1'b0;
		tick(2);
		chk(tx_becoming_empty, 1'b0, "pending reset");
	endtask
	task t_break_rts;
		send_break <= 1'b1;
		tick(2);
		chk(txd, 1'b0, "break");
		send_break <= 1'b0;
		rts_control <= 1'b1;
		tick(2);
		chk({txd, rts_n}, 2'h2, "break end, rts on");
		wr(8'h55);
		cap(3);
		rts_control <= 1'b0;
		tick(2);
		chk(rts_n, 1'b0, "rts held");
		cap(9);
		tick(4);
		chk(rts_n, 1'b1, "rts released");
	endtask
	task t_cts;
		auto_enables <= 1'b1;
		cts_on <= 1'b0;
		tick(8);
		wr(8'h3C);
		cap(4);
		chk(line_bits[31:28], 4'hF, "held by cts");
		cts_on <= 1'b1;
		stop_bits <= `STOP_2;
		parity_enable <= 1'b0;
		tick(8);
		cap(11);
		chk(line_bits[31:21], {2'h3, 8'h3C, 1'b0}, "two stop bits");
		auto_enables <= 1'b0;
	endtask
	task t_sync;
		logic [2:0] md[4];
		logic [15:0] exp;
		md = '{`MODE_MONOSYNC, `MODE_BISYNC, `MODE_EXTSYNC, `MODE_SDLC};
		for (int i = 0; i < 4; i++) begin
			tx_enable <= 1'b0;
			op_mode <= md[i];
			crc_poly_ccitt <= i[0];
			cmd_reset_tx <= 1'b1;
			cmd_reset_crc <= 1'b1;
			tick(1);
			{cmd_reset_tx, cmd_reset_crc} <= 2'h0;
			tx_enable <= 1'b1;
			tick(2);
			cap(16);
			exp = (i == 1) ? {sync_char_high, sync_char_low} : {sync_char_low, sync_char_low};
			if (i == 3) exp = {`SDLC_FLAG, `SDLC_FLAG};
			chk(line_bits[31:16], exp, "idle sync");
			cmd_reset_idle_crc <= (i == 0);
			cmd_send_abort <= (i == 3);
			tick(1);
			{cmd_reset_idle_crc, cmd_send_abort} <= 2'h0;
			tick(2);
			chk(idle_crc_latch, i != 0, "idle crc latch");
			cap(12);
			if (i == 3) chk(line_bits[31:20], 12'hFFF, "abort");
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{data_write, cmd_reset_tx, cmd_reset_tx_pending, cmd_reset_idle_crc} = 4'h0;
		{cmd_reset_crc, cmd_send_abort, tx_enable, send_break, rts_control} = 5'h00;
		{auto_enables, crc_enable, crc_poly_ccitt, run} = 4'h0;
		{parity_enable, parity_even, cts_on} = 3'h7;
		data_in = 8'h00;
		op_mode = `MODE_ASYNC;
		clock_mode = `CLK_X1;
		bits_per_char = 2'h3;
		stop_bits = `STOP_1;
		sync_char_low = 8'h96;
		sync_char_high = 8'hC3;
		reset = 1'b1;
		tick(20);
		reset <= 1'b0;
		tick(2);
		chk({txd, rts_n, tx_buffer_empty, tx_becoming_empty}, 4'hE, "reset");
		chk({tx_request, all_sent, idle_crc_latch, cts_status}, 4'h7, "reset");
		t_async;
		t_break_rts;
		t_cts;
		t_sync;
		give_verdict;
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		miscompares++;
		give_verdict;
	end
endmodule
